//--- test_generator_pkg.sv
// Constants, types and register map for the storage self-test pattern generator.
// Assumes one user clock for all logic and an AXI4-Lite master for the registers.
//
// What this block does
// - Idle request captures size, address, pattern selector
// - Pulse FIFO clear for exactly one cycle
// - Wait for FIFO full to drop
// - Wait until 16 Kbytes are free
// - One cycle prepares each burst header
// - Write enable high 512 cycles per burst
// - Next pattern word computed one cycle ahead
// - Final burst returns generator to idle
// - Short of space: stop writing, wait
// - Enough space: next burst without gap
// - Continue below fill count 3072, else pause
// - FIFO holds 64 Kbytes, never fills
// - FIFO presents head word before acknowledge
// - Write tests send FIFO words as data
// - Read tests check returned data against FIFO
// - Every command moves a fixed 8 Kbytes
// - Word accepted only with command high, no wait
package test_generator_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Data path sizes
	localparam int WORD_W = 128;
	localparam int HDR_W = 64;
	localparam int ADDR_W = 48;
	localparam int LEN_W = 32;
	localparam int SEL_W = 3;
	localparam int FIFO_DEPTH = 4096;
	localparam int CNT_W = 13;
	localparam int IDX_W = 9;

	////////////////////////////////////////////////////////////////////////////////
	// Burst and flow-control figures
	localparam logic [IDX_W-1:0] BURST_LAST_IDX = 9'h1FF;
	localparam logic [IDX_W-1:0] BURST_PREV_IDX = 9'h1FE;
	localparam logic [IDX_W-1:0] BURST_FIRST_IDX = 9'h001;
	localparam logic [LEN_W-1:0] BURST_UNITS = 32'h0000_0010;
	localparam logic [CNT_W-1:0] SPACE_LIMIT = 13'h0C00;
	localparam logic [CNT_W-1:0] WR_NEXT_LIMIT = 13'h0220;
	localparam logic [CNT_W-1:0] WR_START_FILL = 13'h0200;
	localparam int SEED_SHIFT = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Pattern selector codes
	localparam logic [SEL_W-1:0] PAT_INCR = 3'h0;
	localparam logic [SEL_W-1:0] PAT_DECR = 3'h1;
	localparam logic [SEL_W-1:0] PAT_LFSR = 3'h2;
	localparam logic [SEL_W-1:0] PAT_ONES = 3'h3;
	localparam logic [SEL_W-1:0] PAT_ZERO = 3'h4;
	localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
	localparam logic [31:0] LFSR_FILL = 32'h0000_0001;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam int AXI_ADDR_W = 8;
	localparam logic [AXI_ADDR_W-1:0] REG_CONTROL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_TOTAL_SIZE = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] REG_ADDR_LO = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] REG_ADDR_HI = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] REG_PATTERN_SEL = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h14;
	localparam int CTRL_WRITE_BIT = 0;
	localparam int CTRL_READ_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] SIZE_RESET = 32'h0000_0010;

	////////////////////////////////////////////////////////////////////////////////
	// State machines
	typedef enum logic [2:0] {
		gen_idle, gen_clear_fifo, gen_wait_clear_done, gen_wait_space, gen_header, gen_pattern_burst
	} gen_state_t;

	typedef enum logic [2:0] {
		cmd_idle, cmd_read_issue, cmd_write_wait, cmd_write_burst, cmd_write_check, cmd_wait_end
	} cmd_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Memory-map command group toward the host controller, and its answers
	typedef struct packed {
		logic mm_write_command;
		logic mm_read_command;
		logic [ADDR_W-1:0] mm_address;
	} mm_req_t;

	typedef struct packed {
		logic mm_wait_request;
		logic mm_read_valid;
		logic host_busy;
		logic [WORD_W-1:0] mm_read_data;
	} mm_rsp_t;

endpackage

//--- pattern_fifo.sv
// First-word-fall-through FIFO for pattern words with a synchronous clear.
// Assumes writes are never offered while full; the writer throttles on the fill count.
`timescale 1ns/100ps
module pattern_fifo
	import test_generator_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int CW = CNT_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	// Write side
	input wire logic i_wr_en,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_full,
	output logic [CW-1:0] o_fill_count,
	// Read side
	input wire logic i_rd_ack,
	output logic [WIDTH-1:0] o_rd_data,
	output logic o_rd_valid
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr_ff;
	logic [PW:0] rd_ptr_ff;
	logic [PW:0] used;
	logic load;

	// Words in the array, not counting the head register
	assign used = wr_ptr_ff - rd_ptr_ff;
	assign load = (used != '0) && (!o_rd_valid || i_rd_ack);

	// Array storage
	always_ff @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem[wr_ptr_ff[PW-1:0]] <= i_wr_data;
		end
	end

	// Write pointer
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
		end else if (i_clear) begin
			wr_ptr_ff <= '0;
		end else if (i_wr_en) begin
			wr_ptr_ff <= wr_ptr_ff + 1'b1;
		end
	end

	// Head word falls through before any acknowledge
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_ptr_ff <= '0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else if (i_clear) begin
			rd_ptr_ff <= '0;
			o_rd_valid <= 1'b0;
		end else if (load) begin
			o_rd_data <= mem[rd_ptr_ff[PW-1:0]];
			o_rd_valid <= 1'b1;
			rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end else if (i_rd_ack) begin
			o_rd_valid <= 1'b0;
		end
	end

	// Fill count and full flag, one cycle behind the pointers; full stands during clear
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fill_count <= '0;
			o_full <= 1'b1;
		end else if (i_clear) begin
			o_fill_count <= '0;
			o_full <= 1'b1;
		end else begin
			o_fill_count <= CW'(used) + CW'(o_rd_valid);
			o_full <= (used == (PW+1)'(DEPTH));
		end
	end

endmodule

//--- test_generator.sv
// Test pattern source and checker for the memory-map port of a storage host controller.
// Assumes the host controller runs on the same clock and an AXI4-Lite master sets the test.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module test_generator
	import test_generator_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// AXI4-Lite write channels
	input wire logic i_s_axi_awvalid,
	input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
	output logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_wready,
	output logic o_s_axi_bvalid,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_bready,
	// AXI4-Lite read channels
	input wire logic i_s_axi_arvalid,
	input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
	output logic o_s_axi_arready,
	output logic o_s_axi_rvalid,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire logic i_s_axi_rready,
	// Memory-map port toward the host controller
	output mm_req_t o_mm,
	output logic [WORD_W-1:0] o_mm_write_data,
	input wire mm_rsp_t i_mm,
	// Test status
	output logic o_test_busy,
	output logic o_test_fail
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// One step of the pseudo-random lane generator; zero is forced out of the lock-up state
	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		logic [31:0] s;
		s = (v == '0) ? LFSR_FILL : v;
		return s[0] ? ((s >> 1) ^ LFSR_TAPS) : (s >> 1);
	endfunction

	// Four 32-bit lanes of one pattern word
	function automatic logic [WORD_W-1:0] make_word(input logic [SEL_W-1:0] sel, input logic [31:0] seed);
		logic [WORD_W-1:0] w;
		logic [31:0] r;
		w = '0;
		r = seed;
		for (int i = 0; i < 4; i++) begin
			case (sel)
				PAT_INCR: w[32*i +: 32] = seed + 32'(i);
				PAT_DECR: w[32*i +: 32] = ~(seed + 32'(i));
				PAT_LFSR: begin
					w[32*i +: 32] = r;
					r = lfsr_step(r);
				end
				PAT_ONES: w[32*i +: 32] = '1;
				default: w[32*i +: 32] = '0;
			endcase
		end
		return w;
	endfunction

	// Seed of the following word
	function automatic logic [31:0] next_seed(input logic [SEL_W-1:0] sel, input logic [31:0] seed);
		logic [31:0] r;
		r = seed;
		if (sel == PAT_LFSR) begin
			for (int i = 0; i < 4; i++) begin
				r = lfsr_step(r);
			end
		end else begin
			r = seed + 32'h0000_0004;
		end
		return r;
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	gen_state_t generator_state_ff;
	cmd_state_t command_state_ff;
	logic aw_hold_ff;
	logic w_hold_ff;
	logic [AXI_ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [LEN_W-1:0] total_transfer_size_ff;
	logic [ADDR_W-1:0] start_transfer_address_ff;
	logic [SEL_W-1:0] pattern_selector_ff;
	logic write_test_request_ff;
	logic read_test_request_ff;
	logic read_test_ff;
	logic fifo_clear_ff;
	logic fifo_write_enable_ff;
	logic [WORD_W-1:0] pattern_word_ff;
	logic [LEN_W-1:0] pattern_remaining_count_ff;
	logic [ADDR_W-1:0] gen_address_ff;
	logic [SEL_W-1:0] gen_sel_ff;
	logic [31:0] seed_ff;
	logic [IDX_W-1:0] word_idx_ff;
	logic [IDX_W-1:0] cmd_word_ff;
	logic [LEN_W-1:0] cmd_remaining_ff;
	logic host_busy_ff;
	logic fifo_full;
	logic [CNT_W-1:0] fifo_fill_count;
	logic [WORD_W-1:0] fifo_head;
	logic fifo_head_valid;
	logic fifo_ack;
	logic start_any;
	logic do_write;
	logic wr_accept;
	logic gen_last_burst;
	logic cmd_last_burst;
	logic [LEN_W-1:0] load_size;
	logic [HDR_W-1:0] header;
	logic [31:0] rd_value;
	logic rd_hit;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	assign do_write = aw_hold_ff && w_hold_ff && !o_s_axi_bvalid;

	// Write address and data are taken in either order, answered once both are held
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= i_s_axi_awaddr;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= i_s_axi_wdata;
				wstrb_ff <= i_s_axi_wstrb;
				o_s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= (awaddr_ff > REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready <= 1'b1;
			end
		end
	end

	// Writable test settings; request bits become one-cycle pulses
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			total_transfer_size_ff <= SIZE_RESET;
			start_transfer_address_ff <= '0;
			pattern_selector_ff <= PAT_INCR;
			write_test_request_ff <= 1'b0;
			read_test_request_ff <= 1'b0;
		end else begin
			write_test_request_ff <= 1'b0;
			read_test_request_ff <= 1'b0;
			if (do_write) begin
				case ({awaddr_ff[AXI_ADDR_W-1:2], 2'b00})
					REG_CONTROL: begin
						write_test_request_ff <= wstrb_ff[0] && wdata_ff[CTRL_WRITE_BIT];
						read_test_request_ff <= wstrb_ff[0] && wdata_ff[CTRL_READ_BIT] && !wdata_ff[CTRL_WRITE_BIT];
					end
					REG_TOTAL_SIZE: total_transfer_size_ff <= merge(total_transfer_size_ff, wdata_ff, wstrb_ff);
					REG_ADDR_LO: start_transfer_address_ff[31:0] <=
						merge(start_transfer_address_ff[31:0], wdata_ff, wstrb_ff);
					REG_ADDR_HI: start_transfer_address_ff[ADDR_W-1:32] <=
						16'(merge({16'h0000, start_transfer_address_ff[ADDR_W-1:32]}, wdata_ff, wstrb_ff));
					REG_PATTERN_SEL: pattern_selector_ff <= SEL_W'(merge(32'(pattern_selector_ff), wdata_ff, wstrb_ff));
					default: ;
				endcase
			end
		end
	end

	// Read decode
	always_comb begin
		rd_value = '0;
		rd_hit = 1'b1;
		case ({i_s_axi_araddr[AXI_ADDR_W-1:2], 2'b00})
			REG_CONTROL: rd_value = '0;
			REG_TOTAL_SIZE: rd_value = total_transfer_size_ff;
			REG_ADDR_LO: rd_value = start_transfer_address_ff[31:0];
			REG_ADDR_HI: rd_value = {16'h0000, start_transfer_address_ff[ADDR_W-1:32]};
			REG_PATTERN_SEL: rd_value = 32'(pattern_selector_ff);
			REG_STATUS: rd_value = {21'h000000, command_state_ff, 1'b0, generator_state_ff, 2'b00, o_test_fail, o_test_busy};
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= '0;
			o_s_axi_rresp <= RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata <= rd_value;
			o_s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data generator

	assign start_any = (write_test_request_ff || read_test_request_ff)
		&& (generator_state_ff == gen_idle) && (command_state_ff == cmd_idle);
	assign load_size = (total_transfer_size_ff == '0) ? BURST_UNITS : total_transfer_size_ff;
	assign gen_last_burst = (pattern_remaining_count_ff <= BURST_UNITS);
	assign header = {13'h0000, gen_sel_ff, gen_address_ff};

	// Generator state machine
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			generator_state_ff <= gen_idle;
		end else begin
			case (generator_state_ff)
				gen_idle: if (start_any) generator_state_ff <= gen_clear_fifo;
				gen_clear_fifo: generator_state_ff <= gen_wait_clear_done;
				gen_wait_clear_done: if (!fifo_full) generator_state_ff <= gen_wait_space;
				gen_wait_space: if (fifo_fill_count < SPACE_LIMIT) generator_state_ff <= gen_header;
				gen_header: generator_state_ff <= gen_pattern_burst;
				gen_pattern_burst: begin
					if (word_idx_ff == BURST_LAST_IDX) begin
						if (gen_last_burst) begin
							generator_state_ff <= gen_idle;
						end else if (fifo_fill_count < SPACE_LIMIT) begin
							generator_state_ff <= gen_header;
						end else begin
							generator_state_ff <= gen_wait_space;
						end
					end
				end
				default: generator_state_ff <= gen_idle;
			endcase
		end
	end

	// FIFO clear pulse and write enable; header plus 511 pattern cycles give 512 writes
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			fifo_clear_ff <= 1'b0;
			fifo_write_enable_ff <= 1'b0;
		end else begin
			fifo_clear_ff <= (generator_state_ff == gen_idle) && start_any;
			fifo_write_enable_ff <= (generator_state_ff == gen_header)
				|| (generator_state_ff == gen_pattern_burst);
		end
	end

	// Burst bookkeeping: remaining length, burst address, word index
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pattern_remaining_count_ff <= '0;
			gen_address_ff <= '0;
			gen_sel_ff <= PAT_INCR;
			word_idx_ff <= '0;
		end else if (generator_state_ff == gen_idle) begin
			if (start_any) begin
				pattern_remaining_count_ff <= load_size;
				gen_address_ff <= start_transfer_address_ff;
				gen_sel_ff <= pattern_selector_ff;
			end
		end else if (generator_state_ff == gen_header) begin
			word_idx_ff <= BURST_FIRST_IDX;
		end else if (generator_state_ff == gen_pattern_burst) begin
			word_idx_ff <= word_idx_ff + 1'b1;
			if (word_idx_ff == BURST_LAST_IDX) begin
				pattern_remaining_count_ff <= pattern_remaining_count_ff - BURST_UNITS;
				gen_address_ff <= gen_address_ff + ADDR_W'(BURST_UNITS);
			end
		end
	end

	// Pattern word prepared one cycle ahead of its write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pattern_word_ff <= '0;
			seed_ff <= '0;
		end else if (generator_state_ff == gen_idle) begin
			seed_ff <= {start_transfer_address_ff[31-SEED_SHIFT:0], 7'h00};
		end else if (generator_state_ff == gen_header) begin
			pattern_word_ff <= {header, HDR_W'(make_word(gen_sel_ff, seed_ff))};
			seed_ff <= next_seed(gen_sel_ff, seed_ff);
		end else if (generator_state_ff == gen_pattern_burst) begin
			pattern_word_ff <= make_word(gen_sel_ff, seed_ff);
			seed_ff <= next_seed(gen_sel_ff, seed_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pattern FIFO, 4096 words of 128 bits

	pattern_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_WORDS),
		.CW(CNT_W)
	) u_pattern_fifo (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_clear(fifo_clear_ff),
		.i_wr_en(fifo_write_enable_ff),
		.i_wr_data(pattern_word_ff),
		.o_full(fifo_full),
		.o_fill_count(fifo_fill_count),
		.i_rd_ack(fifo_ack),
		.o_rd_data(fifo_head),
		.o_rd_valid(fifo_head_valid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command logic and verification

	assign wr_accept = o_mm.mm_write_command && !i_mm.mm_wait_request;
	assign fifo_ack = wr_accept || i_mm.mm_read_valid;
	assign cmd_last_burst = (cmd_remaining_ff <= BURST_UNITS);
	assign o_mm_write_data = fifo_head;

	// Command state machine and command signals
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			command_state_ff <= cmd_idle;
			o_mm <= '0;
			cmd_remaining_ff <= '0;
			cmd_word_ff <= '0;
			o_test_busy <= 1'b0;
			read_test_ff <= 1'b0;
		end else begin
			case (command_state_ff)
				cmd_idle: begin
					if (start_any) begin
						cmd_remaining_ff <= load_size;
						o_mm.mm_address <= start_transfer_address_ff;
						o_test_busy <= 1'b1;
						read_test_ff <= read_test_request_ff;
						if (read_test_request_ff) begin
							o_mm.mm_read_command <= 1'b1;
							command_state_ff <= cmd_read_issue;
						end else begin
							command_state_ff <= cmd_write_wait;
						end
					end
				end
				cmd_read_issue: begin
					if (!i_mm.mm_wait_request) begin
						if (cmd_last_burst) begin
							o_mm.mm_read_command <= 1'b0;
							command_state_ff <= cmd_wait_end;
						end else begin
							cmd_remaining_ff <= cmd_remaining_ff - BURST_UNITS;
							o_mm.mm_address <= o_mm.mm_address + ADDR_W'(BURST_UNITS);
						end
					end
				end
				cmd_write_wait: begin
					cmd_word_ff <= '0;
					if (fifo_fill_count >= WR_START_FILL) begin
						o_mm.mm_write_command <= 1'b1;
						command_state_ff <= cmd_write_burst;
					end
				end
				cmd_write_burst: begin
					if (wr_accept) begin
						cmd_word_ff <= cmd_word_ff + 1'b1;
						if (cmd_word_ff == BURST_PREV_IDX) begin
							command_state_ff <= cmd_write_check;
						end
					end
				end
				cmd_write_check: begin
					if (wr_accept) begin
						cmd_word_ff <= '0;
						cmd_remaining_ff <= cmd_remaining_ff - BURST_UNITS;
						o_mm.mm_address <= o_mm.mm_address + ADDR_W'(BURST_UNITS);
						if (cmd_last_burst) begin
							o_mm.mm_write_command <= 1'b0;
							command_state_ff <= cmd_wait_end;
						end else if (fifo_fill_count > WR_NEXT_LIMIT) begin
							command_state_ff <= cmd_write_burst;
						end else begin
							o_mm.mm_write_command <= 1'b0;
							command_state_ff <= cmd_write_wait;
						end
					end
				end
				cmd_wait_end: begin
					if (!host_busy_ff) begin
						o_test_busy <= 1'b0;
						command_state_ff <= cmd_idle;
					end
				end
				default: command_state_ff <= cmd_idle;
			endcase
		end
	end

	// Host busy flag through one flip-flop
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			host_busy_ff <= 1'b0;
		end else begin
			host_busy_ff <= i_mm.host_busy;
		end
	end

	// Returned read data compared with the FIFO head; failure sticks until the next test
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_test_fail <= 1'b0;
		end else if (read_test_ff && i_mm.mm_read_valid
			&& (!fifo_head_valid
			|| (i_mm.mm_read_data != fifo_head))) begin
			o_test_fail <= 1'b1;
		end else if (start_any) begin
			o_test_fail <= 1'b0;
		end
	end

endmodule

//--- test_generator_checker.sv
// Checks on the memory-map port of the generator.
// Bound to test_generator; one clock.
`timescale 1ns/100ps
module test_generator_checker import test_generator_pkg::*; (
	// Watched ports
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire mm_req_t o_mm,
	input wire logic [WORD_W-1:0] o_mm_write_data,
	input wire mm_rsp_t i_mm,
	input wire logic o_test_busy,
	input wire logic o_test_fail
);
	logic [8:0] acc_ff;
	wire wr = o_mm.mm_write_command;
	wire rd = o_mm.mm_read_command;
	wire hw = i_mm.mm_wait_request;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////
	// Words taken, modulo one burst
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_ff <= 9'h000;
		end else if (wr && !hw) begin
			acc_ff <= acc_ff + 9'h001;
		end
	end
	sequence held_s;
		wr && hw;
	endsequence
	hold_data_a: assert property (held_s |=> wr && $stable(o_mm_write_data)) else $error("hold");
	hold_addr_a: assert property (held_s |=> $stable(o_mm.mm_address)) else $error("hold");
	hold_read_a: assert property (rd && hw |=> rd && $stable(o_mm.mm_address)) else $error("read");
	read_step_a: assert property (rd && !hw ##1 rd |-> o_mm.mm_address == $past(o_mm.mm_address) + 48'h10)
		else $error("step");
	whole_burst_a: assert property ($fell(wr) |-> acc_ff == 9'h000) else $error("burst");
	one_cmd_a: assert property (!(wr && rd)) else $error("both");
	busy_cmd_a: assert property (wr || rd |-> o_test_busy) else $error("busy");
	fail_keep_a: assert property (o_test_fail |=> o_test_fail || o_test_busy) else $error("fail");
endmodule
bind test_generator test_generator_checker test_generator_checker_inst (.*);

//--- host_mm_model.sv
// Host model on the memory-map link.
// Reads return the all-ones pattern; the bench sets stalls and errors.
`timescale 1ns/100ps
module host_mm_model import test_generator_pkg::*; (
	// Clock, reset, bench controls
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_stall,
	input wire logic i_corrupt,
	// Memory-map link
	input wire mm_req_t i_mm_req,
	output mm_rsp_t o_mm_rsp
);
	logic [ADDR_W-1:0] cmd_q[$];
	logic [ADDR_W-1:0] addr_ff;
	logic [9:0] left_ff;
	// Queue taken reads, then stream 512 words for each
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mm_rsp <= '0;
			left_ff <= 10'h000;
		end else begin
			o_mm_rsp.mm_wait_request <= i_stall;
			if (i_mm_req.mm_read_command && !o_mm_rsp.mm_wait_request) cmd_q.push_back(i_mm_req.mm_address);
			o_mm_rsp.host_busy <= |{i_mm_req.mm_write_command, i_mm_req.mm_read_command, left_ff, cmd_q.size() != 0};
			o_mm_rsp.mm_read_valid <= left_ff != 10'h000;
			o_mm_rsp.mm_read_data <= ~o_mm_rsp.mm_read_data;
			if (left_ff != 10'h000) begin
				o_mm_rsp.mm_read_data <= {left_ff == 10'h200 ? {13'h0, PAT_ONES, addr_ff} : {64{1'b1}}, {63{1'b1}}, ~i_corrupt};
				left_ff <= left_ff - 10'h001;
			end else if (cmd_q.size() != 0) begin
				addr_ff <= cmd_q.pop_front();
				left_ff <= 10'h200;
			end
		end
	end
endmodule

//--- test_test_pattern_fifo_writer.sv
// Bench: registers over AXI4-Lite, host model, queued word compare.
// Design and model share one 40 MHz clock.
`timescale 1ns/100ps
module test_test_pattern_fifo_writer import test_generator_pkg::*;;
	logic i_core_clk = 1'h0, i_rst = 1'h1, hold = 1'h1, bad = 1'h0, stall = 1'h1;
	logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, lo, hi, s;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic o_test_busy, o_test_fail;
	logic [WORD_W-1:0] o_mm_write_data, ew;
	logic [WORD_W-1:0] exq[$];
	mm_req_t o_mm;
	mm_rsp_t i_mm;
	int n_fail = 0, n_compared = 0, cyc = 0, nw = 0;
	test_generator test_generator_inst (.i_core_clk, .i_rst, .i_s_axi_awvalid, .i_s_axi_awaddr, .o_s_axi_awready,
		.i_s_axi_wvalid, .i_s_axi_wdata, .i_s_axi_wstrb(4'hF), .o_s_axi_wready, .o_s_axi_bvalid, .o_s_axi_bresp,
		.i_s_axi_bready, .i_s_axi_arvalid, .i_s_axi_araddr, .o_s_axi_arready, .o_s_axi_rvalid, .o_s_axi_rdata,
		.o_s_axi_rresp, .i_s_axi_rready, .o_mm, .o_mm_write_data, .i_mm, .o_test_busy, .o_test_fail);
	host_mm_model host_mm_model_inst (.i_core_clk, .i_rst, .i_stall(stall), .i_corrupt(bad), .i_mm_req(o_mm),
		.o_mm_rsp(i_mm));
	always #12.5 i_core_clk = ~i_core_clk;
	task automatic chk(input string s, input logic [127:0] e, input logic [127:0] v);
		n_compared++;
		if (e !== v) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One register write or read, response checked, and data checked on reads
	task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge i_core_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_araddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= w;
		i_s_axi_wvalid <= w;
		i_s_axi_bready <= w;
		i_s_axi_arvalid <= !w;
		i_s_axi_rready <= !w;
		do begin
			@(posedge i_core_clk);
			if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
			if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
		end while (!(w ? o_s_axi_bvalid : o_s_axi_rvalid));
		i_s_axi_bready <= 1'h0;
		i_s_axi_rready <= 1'h0;
		chk("resp", r, w ? o_s_axi_bresp : o_s_axi_rresp);
		if (!w) chk("rdata", d, o_s_axi_rdata);
	endtask
	// Start a test, hold the host off for h cycles, wait for the end
	task automatic run(input logic [31:0] u, input logic [1:0] c, input int h);
		ax(1'h1, REG_TOTAL_SIZE, u, RESP_OKAY);
		hold <= 1'h1;
		ax(1'h1, REG_CONTROL, {30'h0, c}, RESP_OKAY);
		repeat (h) @(posedge i_core_clk);
		hold <= 1'h0;
		wait (o_test_busy === 1'h0);
	endtask
	// Host stalls, timeout, compare of each taken write word
	always @(posedge i_core_clk) begin
		stall <= hold | 1'($urandom_range(1));
		cyc++;
		if (o_mm.mm_write_command && !i_mm.mm_wait_request) begin
			if (nw % 512 == 0) chk("waddr", {hi[15:0], lo} + 48'(nw / 32), o_mm.mm_address);
			chk("wdata", exq.pop_front(), o_mm_write_data);
			nw++;
		end
		if (cyc == 60000) begin
			n_fail++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(69303));
		lo = $urandom();
		hi = $urandom_range(65535);
		for (int k = 0; k < 5120; k++) begin
			s = (lo << 7) + 32'(4 * k);
			ew = {s + 32'h3, s + 32'h2, s + 32'h1, s};
			if (k % 512 == 0) ew[127:64] = {13'h0, PAT_INCR, {hi[15:0], lo} + 48'(k / 32)};
			exq.push_back(ew);
		end
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'h0;
		ax(1'h0, REG_TOTAL_SIZE, SIZE_RESET, RESP_OKAY);
		ax(1'h0, 8'h18, 32'h0, RESP_SLVERR);
		ax(1'h1, 8'h18, 32'h0, RESP_SLVERR);
		ax(1'h1, REG_ADDR_LO, lo, RESP_OKAY);
		ax(1'h1, REG_ADDR_HI, hi, RESP_OKAY);
		ax(1'h1, REG_PATTERN_SEL, 32'(PAT_INCR), RESP_OKAY);
		run(32'hA0, 2'h1, 6000);
		chk("left", 0, exq.size());
		ax(1'h1, REG_PATTERN_SEL, 32'(PAT_ONES), RESP_OKAY);
		run(32'h20, 2'h2, 20);
		chk("fail", 0, o_test_fail);
		bad <= 1'h1;
		run(32'h20, 2'h2, 20);
		ax(1'h0, REG_STATUS, 32'h2, RESP_OKAY);
		conclude();
	end
endmodule
